// *** rtl/cpurf_top.sv ***
// Operation
// RULE1: sixteen byte registers pair into eight word registers
// RULE2: data access by full word or either byte half alone
// RULE3: address reads always use the full sixteen-bit register
// RULE4: register seven doubles as stack pointer for calls and exceptions
// RULE5: sixteen-bit next-instruction pointer, low bit always zero
// RULE6: one sixty-four kilobyte address space for code and data
// RULE7: flag byte is I,U,H,U,N,Z,V,C from bit seven down
// RULE8: load, store, and, or, xor ops reach every flag bit
// RULE9: branch conditions come from N, Z, V and C
// RULE10: mask bit set masks interrupts; exception start sets it
// RULE11: bits six and four are free user storage
// RULE12: byte add/sub family sets half-carry from bit three
// RULE13: word add/sub/compare sets half-carry from bit eleven
// RULE14: decimal adjust uses half-carry as an input
// RULE15: N takes result most significant bit
// RULE16: Z set when result is zero, else cleared; shifts test only the low byte, even for word results
// RULE17: V set on arithmetic overflow, else cleared
// RULE18: C is carry, borrow, shifted bit, or bit accumulator
// RULE19: reset loads pointer from vector zero and sets mask
// RULE20: bit ops select one byte bit by number zero to seven
// RULE21: decimal adjust views a byte as two packed digits
// RULE22: flags update in the same cycle as the result write
// RULE23: flags stack as a doubled word; low byte ignored on return
module cpurf_top
    import cpurf_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] rd_a_idx,
    output logic [15:0] rd_a_word,
    output logic [7:0] rd_a_upper,
    output logic [7:0] rd_a_lower,
    input wire logic [2:0] rd_b_idx,
    output logic [15:0] rd_b_word,
    input wire logic [2:0] addr_idx,
    output logic [15:0] addr_word,
    output logic [15:0] stack_top_pointer,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [1:0] wr_lanes,
    input wire logic [15:0] wr_data,
    input wire logic sp_wr_en,
    input wire logic [15:0] sp_wr_data,
    input wire logic pc_wr_en,
    input wire logic [15:0] pc_wr_data,
    output logic [15:0] next_instruction_pointer,
    input wire cpurf_pkg::cpurf_flag_op_t flag_op,
    input wire logic [7:0] flag_imm,
    input wire logic [15:0] flag_pop_word,
    output logic [7:0] condition_flags,
    output logic [15:0] flag_push_word,
    input wire cpurf_pkg::cpurf_alu_op_t alu_op,
    input wire logic alu_word,
    input wire logic [15:0] alu_opa,
    input wire logic [15:0] alu_opb,
    input wire logic alu_carry,
    input wire logic alu_shift_out,
    input wire logic [2:0] bit_num,
    input wire logic [7:0] bit_operand,
    input wire logic [1:0] bit_mode,
    input wire logic [3:0] branch_cond,
    output logic branch_taken,
    input wire logic [7:0] daa_in,
    input wire logic daa_sub,
    output logic [7:0] daa_out,
    output logic daa_carry,
    input wire logic exc_start,
    output logic irq_masked,
    output logic vector_fetch,
    output logic [15:0] vector_addr,
    input wire logic vector_valid,
    input wire logic [15:0] vector_data,
    output logic ready
);
    import cpurf_pkg::*;

    // ****************************************************************
    // general registers
    // ****************************************************************
    logic [7:0] upper_byte_register_q [CPURF_NREG16];
    logic [7:0] lower_byte_register_q [CPURF_NREG16];
    logic [7:0] upper_byte_register_d [CPURF_NREG16];
    logic [7:0] lower_byte_register_d [CPURF_NREG16];
    logic [15:0] pc_q, pc_d;
    logic [7:0] flags_q, flags_d, alu_flags;
    logic bit_sel;
    cpurf_state_t st_q, st_d;

    function automatic logic [15:0] word_of(input logic [2:0] idx,
            input logic [7:0] hi, input logic [7:0] lo);
        word_of = {hi, lo};
    endfunction : word_of

    assign rd_a_word = word_of(rd_a_idx, upper_byte_register_q[rd_a_idx],
        lower_byte_register_q[rd_a_idx]); // RULE1 RULE2
    assign rd_a_upper = upper_byte_register_q[rd_a_idx]; // RULE2
    assign rd_a_lower = lower_byte_register_q[rd_a_idx]; // RULE2
    assign rd_b_word = word_of(rd_b_idx, upper_byte_register_q[rd_b_idx],
        lower_byte_register_q[rd_b_idx]);
    assign addr_word = word_of(addr_idx, upper_byte_register_q[addr_idx],
        lower_byte_register_q[addr_idx]); // RULE3 RULE6
    assign stack_top_pointer = word_of(CPURF_SP_IDX,
        upper_byte_register_q[CPURF_SP_IDX],
        lower_byte_register_q[CPURF_SP_IDX]); // RULE4

    // next values; registers have no reset value by design
    always_comb begin
        for (int i = 0; i < CPURF_NREG16; i++) begin
            upper_byte_register_d[i] = upper_byte_register_q[i];
            lower_byte_register_d[i] = lower_byte_register_q[i];
            if (wr_en && wr_idx == 3'(i)) begin
                if (wr_lanes[1])
                    upper_byte_register_d[i] = wr_data[15:8]; // RULE2
                if (wr_lanes[0])
                    lower_byte_register_d[i] = wr_data[7:0]; // RULE2
            end
            if (sp_wr_en && CPURF_SP_IDX == 3'(i)) begin
                upper_byte_register_d[i] = sp_wr_data[15:8]; // RULE4
                lower_byte_register_d[i] = sp_wr_data[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < CPURF_NREG16; i++) begin
            upper_byte_register_q[i] <= upper_byte_register_d[i];
            lower_byte_register_q[i] <= lower_byte_register_d[i];
        end
    end

    // ****************************************************************
    // flag calculation
    // ****************************************************************
    always_comb begin
        bit_sel = bit_operand[bit_num]; // RULE20
        case (bit_mode)
            2'b00: bit_sel = bit_operand[bit_num];
            2'b01: bit_sel = flags_q[CPURF_FL_C] & bit_operand[bit_num];
            2'b10: bit_sel = flags_q[CPURF_FL_C] | bit_operand[bit_num];
            default: bit_sel = flags_q[CPURF_FL_C] ^ bit_operand[bit_num];
        endcase
    end

    cpurf_flag_calc u_calc (
        .alu_op(alu_op),
        .word_op(alu_word),
        .opa(alu_opa),
        .opb(alu_opb),
        .carry_in(alu_carry),
        .result(wr_data),
        .shift_out(alu_shift_out),
        .bit_acc(bit_sel),
        .flags_in(flags_q),
        .flags_out(alu_flags)
    );

    // ****************************************************************
    // reset sequence, pointer and flags
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        pc_d = pc_q;
        flags_d = flags_q;
        case (st_q)
            CPURF_ST_RESET: st_d = CPURF_ST_VECTOR;
            CPURF_ST_VECTOR: begin
                if (vector_valid) begin
                    pc_d = {vector_data[15:1], 1'b0}; // RULE19 RULE5
                    st_d = CPURF_ST_RUN;
                end
            end
            CPURF_ST_RUN: begin
                if (pc_wr_en)
                    pc_d = {pc_wr_data[15:1], 1'b0}; // RULE5
                flags_d = alu_flags; // RULE22
                case (flag_op)
                    CPURF_FOP_LOAD:
                        flags_d = flag_pop_word[15:8]; // RULE8 RULE23
                    CPURF_FOP_AND: flags_d = flags_q & flag_imm; // RULE8
                    CPURF_FOP_OR: flags_d = flags_q | flag_imm; // RULE8
                    CPURF_FOP_XOR: flags_d = flags_q ^ flag_imm; // RULE8
                    default: flags_d = alu_flags;
                endcase
                if (exc_start)
                    flags_d[CPURF_FL_I] = 1'b1; // RULE10
            end
            default: st_d = CPURF_ST_RESET;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= CPURF_ST_RESET;
            pc_q <= CPURF_PC_RST;
            flags_q <= CPURF_FLAGS_RST; // RULE19
        end else begin
            st_q <= st_d;
            pc_q <= pc_d;
            flags_q <= flags_d;
        end
    end

    assign next_instruction_pointer = {pc_q[15:1], 1'b0}; // RULE5
    assign condition_flags = flags_q; // RULE7 RULE11
    assign flag_push_word = {flags_q, flags_q}; // RULE23
    assign irq_masked = flags_q[CPURF_FL_I]; // RULE10
    assign vector_fetch = (st_q == CPURF_ST_VECTOR);
    assign vector_addr = CPURF_RESET_VECTOR; // RULE19
    assign ready = (st_q == CPURF_ST_RUN);

    // ****************************************************************
    // branch conditions
    // ****************************************************************
    always_comb begin
        logic n, z, v, c;
        n = flags_q[CPURF_FL_N];
        z = flags_q[CPURF_FL_Z];
        v = flags_q[CPURF_FL_V];
        c = flags_q[CPURF_FL_C];
        case (branch_cond[3:1]) // RULE9
            3'h0: branch_taken = 1'b1;
            3'h1: branch_taken = ~(c | z);
            3'h2: branch_taken = ~c;
            3'h3: branch_taken = ~z;
            3'h4: branch_taken = ~v;
            3'h5: branch_taken = ~n;
            3'h6: branch_taken = ~(n ^ v);
            default: branch_taken = ~(z | (n ^ v));
        endcase
        if (branch_cond[0])
            branch_taken = ~branch_taken;
    end

    // ****************************************************************
    // decimal adjust
    // ****************************************************************
    always_comb begin
        logic [3:0] hi, lo;
        logic [7:0] adj;
        logic c, h;
        hi = daa_in[7:4]; // RULE21
        lo = daa_in[3:0]; // RULE21
        c = flags_q[CPURF_FL_C];
        h = flags_q[CPURF_FL_H]; // RULE14
        adj = 8'h00;
        if (h || (!daa_sub && lo > 4'h9))
            adj[3:0] = 4'h6;
        if (c || (!daa_sub && (hi > 4'h9 || (hi == 4'h9 && lo > 4'h9))))
            adj[7:4] = 4'h6;
        daa_out = daa_sub ? daa_in - adj : daa_in + adj;
        daa_carry = c | (adj[7:4] == 4'h6 && !daa_sub);
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_vec_taken;
        vector_fetch && vector_valid;
    endsequence : s_vec_taken

    a_reset_mask: assert property (@(posedge clk) // RULE19
        disable iff (sys_rst) $rose(ready) |-> irq_masked)
        else $error("mask clear after reset");
    a_vec_load: assert property (@(posedge clk) // RULE19 RULE5
        disable iff (sys_rst) s_vec_taken |=> ready
        && next_instruction_pointer == {$past(vector_data[15:1]), 1'b0})
        else $error("pointer not loaded from vector");
    a_hold_flags: assert property (@(posedge clk) // RULE19
        disable iff (sys_rst)
        !ready |=> condition_flags == CPURF_FLAGS_RST)
        else $error("flags changed before run");
    a_pc_even: assert property (@(posedge clk) // RULE5
        disable iff (sys_rst) next_instruction_pointer[0] == 1'b0)
        else $error("pointer low bit set");
    a_pc_load: assert property (@(posedge clk) // RULE5
        disable iff (sys_rst) ready && pc_wr_en
        |=> next_instruction_pointer == {$past(pc_wr_data[15:1]), 1'b0})
        else $error("pointer load wrong");
    a_exc_mask: assert property (@(posedge clk) // RULE10
        disable iff (sys_rst) ready && exc_start |=> irq_masked)
        else $error("mask not set on exception");
    a_push_dup: assert property (@(posedge clk) // RULE23
        disable iff (sys_rst) flag_push_word[15:8] == flag_push_word[7:0])
        else $error("stacked flag halves differ");
    a_load_flags: assert property (@(posedge clk) // RULE23 RULE8
        disable iff (sys_rst) ready && flag_op == CPURF_FOP_LOAD && !exc_start
        |=> condition_flags == $past(flag_pop_word[15:8]))
        else $error("flag load wrong");
    a_zero_flag: assert property (@(posedge clk) // RULE16
        disable iff (sys_rst) ready && flag_op == CPURF_FOP_NONE && !exc_start
        && alu_op == CPURF_AOP_LOGIC && !alu_word && wr_data[7:0] == 8'h00
        |=> condition_flags[CPURF_FL_Z])
        else $error("zero flag missed");
    a_sign_flag: assert property (@(posedge clk) // RULE15
        disable iff (sys_rst) ready && flag_op == CPURF_FOP_NONE
        && alu_op == CPURF_AOP_LOGIC && !alu_word
        |=> condition_flags[CPURF_FL_N] == $past(wr_data[7]))
        else $error("sign flag wrong");
    a_byte_write: assert property (@(posedge clk) // RULE2
        disable iff (sys_rst) wr_en && wr_lanes == 2'b01 && !sp_wr_en
        |=> upper_byte_register_q[$past(wr_idx)]
        == $past(upper_byte_register_q[wr_idx]))
        else $error("upper byte disturbed");
    a_xor_flags: assert property (@(posedge clk) // RULE8
        disable iff (sys_rst) ready && flag_op == CPURF_FOP_XOR && !exc_start
        |=> condition_flags == ($past(condition_flags) ^ $past(flag_imm)))
        else $error("flag xor wrong");
endmodule : cpurf_top

// *** rtl/cpurf_pkg.sv ***
package cpurf_pkg;
    // ****************************************************************
    // widths and flag positions
    // ****************************************************************
    localparam int unsigned CPURF_NREG8 = 16;
    localparam int unsigned CPURF_NREG16 = 8;
    localparam logic [2:0] CPURF_SP_IDX = 3'h7;
    localparam int unsigned CPURF_FL_I = 7;
    localparam int unsigned CPURF_FL_U1 = 6;
    localparam int unsigned CPURF_FL_H = 5;
    localparam int unsigned CPURF_FL_U0 = 4;
    localparam int unsigned CPURF_FL_N = 3;
    localparam int unsigned CPURF_FL_Z = 2;
    localparam int unsigned CPURF_FL_V = 1;
    localparam int unsigned CPURF_FL_C = 0;
    localparam int unsigned CPURF_BYTE_HC = 3;
    localparam int unsigned CPURF_WORD_HC = 11;
    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] CPURF_RESET_VECTOR = 16'h0000;
    localparam logic [7:0] CPURF_FLAGS_RST = 8'h80;
    localparam logic [15:0] CPURF_PC_RST = 16'h0000;

    // flag-register operations
    typedef enum logic [2:0] {
        CPURF_FOP_NONE = 3'b000,
        CPURF_FOP_LOAD = 3'b001,
        CPURF_FOP_AND = 3'b010,
        CPURF_FOP_OR = 3'b011,
        CPURF_FOP_XOR = 3'b100
    } cpurf_flag_op_t;

    // alu-class flag updates
    typedef enum logic [2:0] {
        CPURF_AOP_NONE = 3'b000,
        CPURF_AOP_ADD = 3'b001,
        CPURF_AOP_SUB = 3'b010,
        CPURF_AOP_LOGIC = 3'b011,
        CPURF_AOP_SHIFT = 3'b100,
        CPURF_AOP_BITC = 3'b101
    } cpurf_alu_op_t;

    // reset/vector-fetch sequencing
    typedef enum logic [1:0] {
        CPURF_ST_RESET = 2'b00,
        CPURF_ST_VECTOR = 2'b01,
        CPURF_ST_RUN = 2'b10
    } cpurf_state_t;
endpackage : cpurf_pkg

// *** rtl/cpurf_flag_calc.sv ***
module cpurf_flag_calc
    import cpurf_pkg::*;
(
    input wire cpurf_pkg::cpurf_alu_op_t alu_op,
    input wire logic word_op,
    input wire logic [15:0] opa,
    input wire logic [15:0] opb,
    input wire logic carry_in,
    input wire logic [15:0] result,
    input wire logic shift_out,
    input wire logic bit_acc,
    input wire logic [7:0] flags_in,
    output logic [7:0] flags_out
);
    logic sa, sb, sr, hc;
    logic [12:0] n4;

    always_comb begin
        sa = word_op ? opa[15] : opa[7];
        sb = word_op ? opb[15] : opb[7];
        sr = word_op ? result[15] : result[7];
        n4 = 13'h0000;
        n4 = word_op ? {1'b0, opa[11:0]} + {1'b0, opb[11:0]}
            : {8'h00, 1'b0, opa[3:0]} + {8'h00, 1'b0, opb[3:0]};
        hc = word_op ? n4[12] : n4[4];
        if (alu_op == CPURF_AOP_SUB) begin
            hc = word_op ? (opa[11:0] < opb[11:0])
                : (opa[3:0] < opb[3:0]); // RULE12 RULE13
        end
        flags_out = flags_in;
        case (alu_op)
            CPURF_AOP_ADD, CPURF_AOP_SUB: begin
                flags_out[CPURF_FL_H] = hc; // RULE12 RULE13
                flags_out[CPURF_FL_N] = sr; // RULE15
                flags_out[CPURF_FL_Z] = word_op ? (result == 16'h0000)
                    : (result[7:0] == 8'h00); // RULE16
                flags_out[CPURF_FL_V] = (alu_op == CPURF_AOP_ADD)
                    ? (sa == sb) && (sr != sa)
                    : (sa != sb) && (sr != sa); // RULE17
                flags_out[CPURF_FL_C] = carry_in; // RULE18
            end
            CPURF_AOP_LOGIC: begin
                flags_out[CPURF_FL_N] = sr; // RULE15
                flags_out[CPURF_FL_Z] = word_op ? (result == 16'h0000)
                    : (result[7:0] == 8'h00); // RULE16
                flags_out[CPURF_FL_V] = 1'b0; // RULE17
            end
            CPURF_AOP_SHIFT: begin
                flags_out[CPURF_FL_N] = sr;
                flags_out[CPURF_FL_Z] = (result[7:0] == 8'h00);
                flags_out[CPURF_FL_V] = 1'b0;
                flags_out[CPURF_FL_C] = shift_out; // RULE18
            end
            CPURF_AOP_BITC: flags_out[CPURF_FL_C] = bit_acc; // RULE18
            default: flags_out = flags_in;
        endcase
    end
endmodule : cpurf_flag_calc

// *** bench/cpurf_partner.sv ***
module cpurf_partner (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic vector_fetch,
    input wire logic [15:0] vector_addr,
    input wire logic [3:0] lat,
    input wire logic [15:0] vec_word,
    output logic vector_valid,
    output logic [15:0] vector_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // ****************************************************************
    // vector memory: answers word zero after lat cycles
    // ****************************************************************
    always @(negedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt = 0;
            vector_valid = 0;
            vector_data = ~vec_word;
        end else if (vector_fetch && vector_addr === 16'h0000) begin
            if (cnt >= lat) begin
                vector_valid = 1;
                vector_data = vec_word;
            end else begin
                cnt++;
                vector_data = ~vector_data;
            end
        end else begin
            vector_valid = 0;
            cnt = 0;
            vector_data = ~vector_data;
        end
    end
endmodule : cpurf_partner

// *** bench/tb_top.sv ***
module tb_top;
    import cpurf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, wr_en, sp_wr_en, pc_wr_en, alu_word, alu_carry;
    logic alu_shift_out, daa_sub, exc_start, vector_valid, ready;
    logic branch_taken, daa_carry, irq_masked, vector_fetch;
    logic [2:0] rd_a_idx, rd_b_idx, addr_idx, wr_idx, bit_num;
    logic [1:0] wr_lanes, bit_mode;
    logic [3:0] branch_cond, lat;
    logic [7:0] rd_a_upper, rd_a_lower, flag_imm, condition_flags, fl;
    logic [7:0] bit_operand, daa_in, daa_out;
    logic [15:0] rd_a_word, rd_b_word, addr_word, stack_top_pointer;
    logic [15:0] wr_data, sp_wr_data, pc_wr_data, next_instruction_pointer;
    logic [15:0] flag_pop_word, flag_push_word, alu_opa, alu_opb;
    logic [15:0] vector_addr, vector_data, vec_word;
    logic [15:0] rm [8];
    cpurf_flag_op_t flag_op;
    cpurf_alu_op_t alu_op;
    int seed, n_errors, tests_run, d, s;
    cpurf_top i_dut (.clk, .sys_rst, .rd_a_idx, .rd_a_word, .rd_a_upper,
        .rd_a_lower, .rd_b_idx, .rd_b_word, .addr_idx, .addr_word,
        .stack_top_pointer, .wr_en, .wr_idx, .wr_lanes, .wr_data, .sp_wr_en,
        .sp_wr_data, .pc_wr_en, .pc_wr_data, .next_instruction_pointer,
        .flag_op, .flag_imm, .flag_pop_word, .condition_flags,
        .flag_push_word, .alu_op, .alu_word, .alu_opa, .alu_opb, .alu_carry,
        .alu_shift_out, .bit_num, .bit_operand, .bit_mode, .branch_cond,
        .branch_taken, .daa_in, .daa_sub, .daa_out, .daa_carry, .exc_start,
        .irq_masked, .vector_fetch, .vector_addr, .vector_valid,
        .vector_data, .ready);
    cpurf_partner i_far (.clk, .sys_rst, .vector_fetch, .vector_addr, .lat,
        .vec_word, .vector_valid, .vector_data);
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic wr(logic [2:0] i, logic [1:0] ln, logic [15:0] dt);
        wr_en = 1;
        wr_idx = i;
        wr_lanes = ln;
        wr_data = dt;
        if (ln[1]) rm[i][15:8] = dt[15:8];
        if (ln[0]) rm[i][7:0] = dt[7:0];
        @(negedge clk);
        wr_en = 0;
        alu_op = CPURF_AOP_NONE;
        sp_wr_en = 0;
    endtask : wr
    task automatic ckreg(logic [2:0] i);
        rd_a_idx = i;
        rd_b_idx = i;
        addr_idx = i;
        @(negedge clk);
        chk("word", rd_a_word, rm[i]);
        chk("upper", rd_a_upper, rm[i][15:8]);
        chk("lower", rd_a_lower, rm[i][7:0]);
        chk("word_b", rd_b_word, rm[i]);
        chk("addr", addr_word, rm[i]);
        chk("sp", stack_top_pointer, rm[7]);
    endtask : ckreg
    task automatic fop(cpurf_flag_op_t op, logic [7:0] im, logic [15:0] pw);
        flag_op = op;
        flag_imm = im;
        flag_pop_word = pw;
        case (op)
            CPURF_FOP_LOAD: fl = pw[15:8];
            CPURF_FOP_AND: fl &= im;
            CPURF_FOP_OR: fl |= im;
            default: fl ^= im;
        endcase
        @(negedge clk);
        flag_op = CPURF_FOP_NONE;
        chk("flags", condition_flags, fl);
        chk("push", flag_push_word, {fl, fl});
    endtask : fop
    task automatic do_reset(logic [3:0] l, logic [15:0] v);
        int n;
        sys_rst = 1;
        lat = l;
        vec_word = v;
        repeat (10) @(negedge clk);
        chk("rst_flags", condition_flags, 8'h80);
        chk("rst_ready", ready, 0);
        sys_rst = 0;
        flag_op = CPURF_FOP_AND;
        flag_imm = 8'h00;
        pc_wr_en = 1;
        pc_wr_data = 16'h2222;
        @(negedge clk);
        chk("fetch", vector_fetch, 1);
        chk("vaddr", vector_addr, 16'h0000);
        n = 0;
        while (ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        flag_op = CPURF_FOP_NONE;
        pc_wr_en = 0;
        chk("ready", ready, 1);
        chk("mask", irq_masked, 1);
        chk("flags", condition_flags, 8'h80);
        chk("nip", next_instruction_pointer, v & 16'hfffe);
        fl = 8'h80;
    endtask : do_reset
    task automatic arith(bit sb, bit w, logic [15:0] a, logic [15:0] b);
        int m, hm, r, h, t;
        logic [15:0] res;
        m = w ? 'hffff : 'hff;
        hm = w ? 'hfff : 'hf;
        t = w ? 15 : 7;
        a = a & m;
        b = b & m;
        r = sb ? int'(a) - int'(b) : int'(a) + int'(b);
        h = sb ? int'(a & hm) - int'(b & hm) : int'(a & hm) + int'(b & hm);
        res = r[15:0] & m;
        fl[5] = sb ? h < 0 : h > hm;
        fl[0] = sb ? r < 0 : r > m;
        fl[3] = res[t];
        fl[2] = res == 0;
        fl[1] = (a[t] ^ res[t]) & (sb ? a[t] ^ b[t] : !(a[t] ^ b[t]));
        alu_op = sb ? CPURF_AOP_SUB : CPURF_AOP_ADD;
        alu_word = w;
        alu_opa = a;
        alu_opb = b;
        alu_carry = fl[0];
        wr(2, w ? 2'b11 : 2'b01, w ? res : {a[15:8] ^ 8'h5a, res[7:0]});
        chk("aflags", condition_flags, fl);
        ckreg(2);
    endtask : arith
    function automatic bit br(logic [3:0] c, logic [7:0] f);
        bit n, z, v, cy, r;
        n = f[CPURF_FL_N];
        z = f[CPURF_FL_Z];
        v = f[CPURF_FL_V];
        cy = f[CPURF_FL_C];
        case (c[3:1])
            3'h0: r = 1;
            3'h1: r = !(cy | z);
            3'h2: r = !cy;
            3'h3: r = !z;
            3'h4: r = !v;
            3'h5: r = !n;
            3'h6: r = !(n ^ v);
            default: r = !(z | (n ^ v));
        endcase
        return r ^ c[0];
    endfunction : br
    function automatic logic [8:0] dadj(logic [7:0] a, bit sb, bit h, bit c);
        bit up, lo;
        up = c || a > 8'h99;
        lo = h || a[3:0] > 4'h9;
        if (sb) return {c, a - (c ? 8'h60 : 8'h00) - (h ? 8'h06 : 8'h00)};
        return {up, a + (up ? 8'h60 : 8'h00) + (lo ? 8'h06 : 8'h00)};
    endfunction : dadj
    // ****************************************************************
    // clock, watchdog and main sequence
    // ****************************************************************
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(8 * 3000);
        n_errors++;
        report_and_stop();
    end
    initial begin
        {wr_en, sp_wr_en, pc_wr_en, alu_word, alu_carry, alu_shift_out} = 0;
        {daa_sub, exc_start, rd_a_idx, rd_b_idx, addr_idx, wr_idx} = 0;
        {bit_num, wr_lanes, bit_mode, branch_cond, flag_imm, bit_operand} = 0;
        {daa_in, wr_data, sp_wr_data, pc_wr_data, flag_pop_word} = 0;
        {alu_opa, alu_opb} = 0;
        flag_op = CPURF_FOP_NONE;
        alu_op = CPURF_AOP_NONE;
        seed = 52436;
        do_reset(0, 16'h1235);
        for (int i = 0; i < 8; i++) wr(i, 2'b11, $random(seed));
        wr(3, 2'b10, $random(seed));
        wr(3, 2'b01, $random(seed));
        sp_wr_en = 1;
        sp_wr_data = $random(seed);
        wr(7, 2'b11, 16'h1111);
        rm[7] = sp_wr_data;
        for (int i = 0; i < 8; i++) ckreg(i);
        for (int i = 0; i < 12; i++) begin
            d = $random(seed);
            fop(cpurf_flag_op_t'(i % 4 + 1), d[7:0], d[15:0]);
        end
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            fop(CPURF_FOP_LOAD, 8'h00, {d[7:0], ~d[7:0]});
            for (int c = 0; c < 16; c++) begin
                d = $random(seed) & 'hff;
                branch_cond = c;
                daa_sub = c % 2;
                daa_in = 8'(16 * ((d >> 4) % 10) + d % 10);
                @(negedge clk);
                chk("branch", branch_taken, br(c, fl));
                d = dadj(daa_in, daa_sub, fl[5], fl[0]);
                chk("daa", {daa_carry, daa_out}, d[8:0]);
            end
        end
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            s = (i % 4 == 3) ? d : $random(seed);
            arith(i % 2, i / 2 % 2, d, s);
        end
        for (int i = 0; i < 12; i++) begin
            d = $random(seed);
            s = $random(seed);
            if (i % 3 == 2) begin
                bit_num = s[2:0];
                bit_mode = s[4:3];
                bit_operand = d[7:0];
                alu_op = CPURF_AOP_BITC;
                case (bit_mode)
                    2'h0: fl[0] = d[s[2:0]];
                    2'h1: fl[0] &= d[s[2:0]];
                    2'h2: fl[0] |= d[s[2:0]];
                    default: fl[0] ^= d[s[2:0]];
                endcase
                @(negedge clk);
                alu_op = CPURF_AOP_NONE;
            end else begin
                if (i % 3 == 1) fl[0] = s[0];
                d = (i == 0) ? 0 : d;
                fl[3:1] = {d[7], d[7:0] == 0, 1'b0};
                alu_shift_out = s[0];
                alu_word = 0;
                alu_op = (i % 3) ? CPURF_AOP_SHIFT : CPURF_AOP_LOGIC;
                wr(1, 2'b01, d[15:0]);
            end
            chk("mflags", condition_flags, fl);
        end
        fop(CPURF_FOP_AND, 8'h7f, 16'h0000);
        chk("unmask", irq_masked, 0);
        exc_start = 1;
        @(negedge clk);
        exc_start = 0;
        fl[7] = 1;
        chk("exc_mask", irq_masked, 1);
        chk("exc_flags", condition_flags, fl);
        pc_wr_en = 1;
        pc_wr_data = 16'hbeef;
        @(negedge clk);
        pc_wr_en = 0;
        chk("nip_wr", next_instruction_pointer, 16'hbeee);
        do_reset(5, 16'h0043);
        report_and_stop();
    end
endmodule : tb_top
